// ===== common/rscs_pkg.sv
// Constants and types for the reset source and clock select block
package rscs_pkg;
  // Configuration word and its fields
  localparam int          RSCS_CFG_W         = 14;
  localparam logic [13:0] RSCS_CFG_ERASED    = 14'h3fff;
  localparam int          RSCS_SEL_LO_POS    = 0;
  localparam int          RSCS_SEL_HI_POS    = 1;
  localparam int          RSCS_PWUP_EN_N_POS = 3;
  localparam int          RSCS_BROWN_EN_POS  = 6;

  // Oscillator modes, encoded as the two select bits
  typedef enum logic [1:0] {
    RSCS_LOW_POWER_CRYSTAL_MODE  = 2'b00,
    RSCS_CRYSTAL_MODE            = 2'b01,
    RSCS_HIGH_SPEED_CRYSTAL_MODE = 2'b10,
    RSCS_RESISTOR_CAPACITOR_MODE = 2'b11
  } rscs_osc_mode_t;

  // Reset causes, one-hot
  localparam int         RSCS_CAUSE_W        = 6;
  localparam logic [5:0] RSCS_CAUSE_POR      = 6'h01;
  localparam logic [5:0] RSCS_CAUSE_CLR_RUN  = 6'h02;
  localparam logic [5:0] RSCS_CAUSE_CLR_SLP  = 6'h04;
  localparam logic [5:0] RSCS_CAUSE_DOG_RST  = 6'h08;
  localparam logic [5:0] RSCS_CAUSE_DOG_WAKE = 6'h10;
  localparam logic [5:0] RSCS_CAUSE_BROWN    = 6'h20;

  // Timing
  localparam int          RSCS_CLK_HZ         = 10_000_000;
  localparam int          RSCS_PWUP_MS        = 72;
  localparam int          RSCS_PWUP_CYC       = RSCS_PWUP_MS * (RSCS_CLK_HZ / 1000);
  localparam int          RSCS_STUP_CYC       = 1024;
  localparam int          RSCS_CNT_W          = 20;
  localparam logic [10:0] RSCS_STUP_LAST      = 11'h3ff;
  localparam int          RSCS_FILT_CYC       = 4;
  localparam logic [2:0]  RSCS_FILT_LAST      = 3'h3;

  // Sequencer states
  typedef enum logic [2:0] {
    RSCS_ST_HOLD = 3'b000,
    RSCS_ST_PWUP = 3'b001,
    RSCS_ST_STUP = 3'b010,
    RSCS_ST_RUN  = 3'b011,
    RSCS_ST_WAIT = 3'b100
  } rscs_state_t;
endpackage : rscs_pkg

// ===== logic/rscs_master_clear_pin_filter.sv
// Glitch filter on the master-clear input
`timescale 1ns/1ns
module rscs_clear_filter
  import rscs_pkg::*;
(
  input  wire logic clk_sys,          // System clock
  input  wire logic srst,             // Synchronous reset, high
  input  wire logic master_clear_n,   // Raw master-clear pin level, low asserts
  output logic      clear_active      // Filtered master-clear, high while held
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       act;
  } rscs_filt_t;

  rscs_filt_t st;
  rscs_filt_t next_st;

  // Level must stand for the full count before it is believed
  always_comb begin
    next_st = st;
    if ((!master_clear_n) == st.act) begin
      next_st.cnt = 3'h0;
    end else if (st.cnt == RSCS_FILT_LAST) begin
      next_st.act = !master_clear_n;
      next_st.cnt = 3'h0;
    end else begin
      next_st.cnt = st.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clear_active = st.act;

  // A one-cycle pulse must not reach the output in the span that follows
  a_filter_short_pulse : assert property (@(posedge clk_sys) disable iff (srst)
    (!clear_active && $fell(master_clear_n)) ##1 master_clear_n |-> !clear_active [*4])
    else $error("short master-clear pulse passed the filter");
endmodule : rscs_clear_filter

// ===== logic/rscs_reset_seq.sv
// Reset cause classification, time-out sequence and oscillator mode select
//
// Overview of operation
// - Erased configuration word reads all ones; every option takes its default.
// - Two select bits pick one of four oscillator modes.
// - Crystal modes run a crystal between oscillator input and output pins.
// - High-speed mode also accepts an external clock on the input pin.
// - Six reset causes are told apart.
// - Never-reset registers keep contents through all resets but power-on.
// - Other registers reset on power-on, master-clear, watchdog reset, brown-out.
// - Watchdog wake-up resets nothing and resumes execution.
// - Expiry and power-down flags are set per cause.
// - Short master-clear pulses are filtered out.
// - Watchdog reset never drives the master-clear pin.
// - Rising supply detection starts the power-on reset sequence.
// - Start-up timer counts 1024 oscillator-input cycles after power-up delay.
// - Start-up delay only in crystal modes, on power-on, brown-out or wake-up.
// - Power-on status flag clears on power-on only.
`timescale 1ns/1ns
module rscs_reset_seq
  import rscs_pkg::*;
#(
  parameter int PWUP_CYC = RSCS_PWUP_CYC  // Power-up delay in clocks
)(
  input  wire logic        clk_sys,          // System clock
  input  wire logic        srst,             // Synchronous reset, high
  input  wire logic [13:0] config_word,      // Non-volatile configuration word
  input  wire logic        config_erased,    // High when config memory is blank
  input  wire logic        supply_rise,      // Pulse: supply rise detected
  input  wire logic        brownout_det,     // Level: supply below brown-out point
  input  wire logic        master_clear_n,   // Master-clear pin, low asserts
  input  wire logic        watchdog_expire,  // Pulse: watchdog timer ran out
  input  wire logic        cpu_sleeping,     // Level: core is in sleep
  input  wire logic        osc_in_pin,       // Oscillator input pin level
  input  wire logic        ext_clk_sel,      // Board uses external clock on input pin
  input  wire logic        por_flag_set,     // Pulse: software sets power-on flag
  output logic [1:0]       osc_mode,         // Selected oscillator mode
  output logic             osc_drive_en,     // Inverting amplifier drives output pin
  output logic             chip_reset,       // Holds general registers in reset
  output logic             keep_reset,       // Resets never-reset class too
  output logic             wake_resume,      // Pulse: resume after watchdog wake-up
  output logic [5:0]       reset_cause,      // One-hot cause of last reset
  output logic             expiry_flag,      // Expiry flag
  output logic             powerdown_flag,   // Power-down flag
  output logic             por_status,       // Power-on status flag
  output logic             pin_drive_n       // Master-clear pin drive, never used
);
  typedef struct packed {
    rscs_state_t state;
    logic [19:0] cnt;
    logic [10:0] startup;
    logic        osc_q;
    logic [5:0]  cause;
    logic        expiry;
    logic        pdown;
    logic        por;
    logic        keep;
    logic        resume;
  } rscs_seq_t;

  rscs_seq_t   st;
  rscs_seq_t   next_st;
  logic        clear_active;
  logic [13:0] cfg;
  logic        crystal;
  logic        pwup_on;
  logic        brown_on;

  // Filter sits ahead of the classifier so glitches never reach a cause
  rscs_clear_filter u_filter (
    .clk_sys        (clk_sys),
    .srst           (srst),
    .master_clear_n (master_clear_n),
    .clear_active   (clear_active)
  );

  // Blank memory reads as all ones, so defaults apply
  assign cfg      = config_erased ? RSCS_CFG_ERASED : config_word;
  assign osc_mode = {cfg[RSCS_SEL_HI_POS], cfg[RSCS_SEL_LO_POS]};
  // Crystal amplifier only in crystal modes; external clock needs it off
  assign crystal  = (osc_mode != RSCS_RESISTOR_CAPACITOR_MODE);
  assign osc_drive_en = crystal &&
    !(ext_clk_sel && osc_mode == RSCS_HIGH_SPEED_CRYSTAL_MODE);
  // Brown-out enable forces the power-up delay on
  assign brown_on = cfg[RSCS_BROWN_EN_POS];
  assign pwup_on  = !cfg[RSCS_PWUP_EN_N_POS] || brown_on;

  // Cause classification and time-out sequence
  always_comb begin
    next_st = st;
    next_st.osc_q  = osc_in_pin;
    next_st.resume = 1'b0;
    next_st.keep   = 1'b0;
    if (supply_rise) begin
      next_st.cause  = RSCS_CAUSE_POR;
      next_st.expiry = 1'b1;
      next_st.pdown  = 1'b1;
      next_st.por    = 1'b0;
      next_st.keep   = 1'b1;
      next_st.state  = RSCS_ST_HOLD;
      next_st.cnt    = '0;
    end else if (brown_on && brownout_det) begin
      next_st.cause  = RSCS_CAUSE_BROWN;
      next_st.expiry = 1'b1;
      next_st.pdown  = 1'b1;
      next_st.state  = RSCS_ST_HOLD;
      next_st.cnt    = '0;
    end else if (clear_active) begin
      // A wake-up still timing its start-up is asleep, so it must reset too
      if (st.state == RSCS_ST_RUN || st.cause == RSCS_CAUSE_DOG_WAKE) begin
        next_st.cause = cpu_sleeping ? RSCS_CAUSE_CLR_SLP : RSCS_CAUSE_CLR_RUN;
        if (cpu_sleeping) begin
          next_st.expiry = 1'b1;
          next_st.pdown  = 1'b0;
        end
      end
      next_st.state = RSCS_ST_WAIT;
    end else if (watchdog_expire && st.state == RSCS_ST_RUN) begin
      next_st.expiry = 1'b0;
      if (cpu_sleeping) begin
        next_st.cause   = RSCS_CAUSE_DOG_WAKE;
        next_st.pdown   = 1'b0;
        next_st.state   = crystal ? RSCS_ST_STUP : RSCS_ST_RUN;
        next_st.startup = '0;
        next_st.resume  = !crystal;
      end else begin
        // Internal only: the pin driver stays released
        next_st.cause = RSCS_CAUSE_DOG_RST;
        next_st.pdown = 1'b1;
        next_st.state = RSCS_ST_WAIT;
      end
    end else begin
      case (st.state)
        RSCS_ST_HOLD: begin
          next_st.state   = pwup_on ? RSCS_ST_PWUP : (crystal ? RSCS_ST_STUP : RSCS_ST_RUN);
          next_st.cnt     = '0;
          next_st.startup = '0;
        end
        RSCS_ST_PWUP: begin
          next_st.cnt = st.cnt + 20'h1;
          if (st.cnt == RSCS_CNT_W'(PWUP_CYC - 1)) begin
            next_st.state = crystal ? RSCS_ST_STUP : RSCS_ST_RUN;
          end
        end
        RSCS_ST_STUP: begin
          // Counts rising edges of the oscillator input
          if (osc_in_pin && !st.osc_q) begin
            next_st.startup = st.startup + 11'h1;
            if (st.startup == RSCS_STUP_LAST) begin
              next_st.state  = RSCS_ST_RUN;
              next_st.resume = (st.cause == RSCS_CAUSE_DOG_WAKE);
            end
          end
        end
        // Master-clear released or watchdog reset: no power-up or start-up delay runs, start at once
        RSCS_ST_WAIT: next_st.state = RSCS_ST_RUN;
        default:      next_st.state = st.state;
      endcase
    end
    // Power-on clear wins over a simultaneous software set
    if (por_flag_set && !supply_rise) begin
      next_st.por = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st        <= '0;
      st.state  <= RSCS_ST_HOLD;
      st.cause  <= RSCS_CAUSE_POR;
      st.expiry <= 1'b1;
      st.pdown  <= 1'b1;
      st.keep   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Wake-up is not a reset: registers stay put
  assign chip_reset = (st.state != RSCS_ST_RUN) &&
                      (st.cause != RSCS_CAUSE_DOG_WAKE);
  assign keep_reset     = st.keep;
  assign wake_resume    = st.resume;
  assign reset_cause    = st.cause;
  assign expiry_flag    = st.expiry;
  assign powerdown_flag = st.pdown;
  assign por_status     = st.por;
  assign pin_drive_n    = 1'b1;

  sequence s_rise;
    supply_rise;
  endsequence
  sequence s_flags_por;
    expiry_flag && powerdown_flag && !por_status && reset_cause == RSCS_CAUSE_POR;
  endsequence

  a_por_flags : assert property (@(posedge clk_sys) disable iff (srst)
    s_rise |=> s_flags_por)
    else $error("power-on flags wrong");
  a_cause_onehot : assert property (@(posedge clk_sys) disable iff (srst)
    $onehot(reset_cause))
    else $error("reset cause not one-hot");
  a_dog_no_pin : assert property (@(posedge clk_sys) disable iff (srst)
    watchdog_expire |-> ##[0:2] pin_drive_n)
    else $error("watchdog drove master-clear pin");
  a_wake_no_reset : assert property (@(posedge clk_sys) disable iff (srst)
    reset_cause == RSCS_CAUSE_DOG_WAKE |-> !chip_reset && !expiry_flag && !powerdown_flag)
    else $error("watchdog wake-up reset registers");
  // The pulse left standing by the synchronous reset counts as a power-on
  a_keep_por_only : assert property (@(posedge clk_sys) disable iff (srst)
    keep_reset |-> $past(supply_rise) || $past(srst))
    else $error("never-reset class cleared without power-on");
  a_rc_no_ost : assert property (@(posedge clk_sys) disable iff (srst)
    osc_mode == RSCS_RESISTOR_CAPACITOR_MODE |-> st.state != RSCS_ST_STUP)
    else $error("start-up timer ran in resistor-capacitor mode");
  a_mode_decode : assert property (@(posedge clk_sys) disable iff (srst)
    config_erased |-> osc_mode == RSCS_RESISTOR_CAPACITOR_MODE && !osc_drive_en)
    else $error("erased config did not give default mode");
  a_reset_held : assert property (@(posedge clk_sys) disable iff (srst)
    $rose(clear_active) |=> chip_reset)
    else $error("master-clear did not reset registers");
  a_por_stable : assert property (@(posedge clk_sys) disable iff (srst)
    !supply_rise && !por_flag_set |=> $stable(por_status))
    else $error("power-on flag changed without cause");
endmodule : rscs_reset_seq

// ===== verification/rscs_far_side.sv
// Far-side model: pulled-up master-clear pin and oscillator source
`timescale 1ns/1ns
module rscs_far_side (
  input  wire logic clk_sys,          // System clock
  input  wire logic press_n,          // Button or supervisor pulls pin low
  input  wire logic pin_drive_n,      // Device drive onto the pin
  output logic      master_clear_n,   // Wired pin level
  output logic      osc_in_pin        // Crystal or external clock
);
  // Pull-up holds the pin high unless a party pulls it down
  assign master_clear_n = press_n & pin_drive_n;

  // Free-running source, half the system rate, so start-up counts stay short
  initial osc_in_pin = 1'b0;
  always @(posedge clk_sys) osc_in_pin <= ~osc_in_pin;
endmodule : rscs_far_side

// ===== verification/rscs_reset_seq_test.sv
// Self-checking bench for reset cause and clock mode selection
`timescale 1ns/1ns
module rscs_reset_seq_test;
  import rscs_pkg::*;
  logic        clk_sys, srst, config_erased, supply_rise, brownout_det, watchdog_expire;
  logic        cpu_sleeping, ext_clk_sel, por_flag_set, press_n, master_clear_n, osc_in_pin;
  logic        osc_drive_en, chip_reset, keep_reset, wake_resume, expiry_flag;
  logic        powerdown_flag, por_status, pin_drive_n, kr_s, cr_s, cr_q;
  logic [13:0] config_word;
  logic [1:0]  osc_mode;
  logic [5:0]  reset_cause;
  logic [10:0] note_q[$];
  int          err_total, tests_run, cyc;

  rscs_reset_seq #(.PWUP_CYC(20)) dut (.clk_sys(clk_sys), .srst(srst),
    .config_word(config_word), .config_erased(config_erased), .supply_rise(supply_rise),
    .brownout_det(brownout_det), .master_clear_n(master_clear_n),
    .watchdog_expire(watchdog_expire), .cpu_sleeping(cpu_sleeping), .osc_in_pin(osc_in_pin),
    .ext_clk_sel(ext_clk_sel), .por_flag_set(por_flag_set), .osc_mode(osc_mode),
    .osc_drive_en(osc_drive_en), .chip_reset(chip_reset), .keep_reset(keep_reset),
    .wake_resume(wake_resume), .reset_cause(reset_cause), .expiry_flag(expiry_flag),
    .powerdown_flag(powerdown_flag), .por_status(por_status),
    .pin_drive_n(pin_drive_n));

  rscs_far_side far (.clk_sys(clk_sys), .press_n(press_n),
    .pin_drive_n(pin_drive_n), .master_clear_n(master_clear_n),
    .osc_in_pin(osc_in_pin));

  // Clock, and a cycle ceiling well above the slowest power-on sequences
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic check(input logic [10:0] seen, input logic [10:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // Result shows at reset release or wake-up; an unexpected one meets an empty queue
  initial cr_q = 1'b1;
  always @(posedge clk_sys) begin
    if (keep_reset) kr_s = 1'b1;
    if (chip_reset && !cr_q) cr_s = 1'b1;
    if ((cr_q && !chip_reset) || wake_resume) begin
      if (note_q.size() == 0) check(11'h0, 11'h7ff);
      else check({reset_cause, expiry_flag, powerdown_flag, por_status, kr_s, cr_s},
                 note_q.pop_front());
      kr_s = 1'b0;
      cr_s = 1'b0;
    end
    cr_q = chip_reset;
  end

  // Assert one source for len cycles; a noted event waits for its result
  task automatic hit(input int kind, input int len, input bit push, input logic [10:0] note);
    if (push) note_q.push_back(note);
    @(posedge clk_sys);
    case (kind)
      0: supply_rise <= 1'b1;
      1: brownout_det <= 1'b1;
      2: press_n <= 1'b0;
      default: watchdog_expire <= 1'b1;
    endcase
    repeat (len) @(posedge clk_sys);
    supply_rise <= 1'b0;
    brownout_det <= 1'b0;
    press_n <= 1'b1;
    watchdog_expire <= 1'b0;
    for (int i = 0; i < 4000 && note_q.size() != 0; i++) @(posedge clk_sys);
    repeat (40) @(posedge clk_sys);
  endtask : hit

  initial begin
    logic x;
    void'($urandom(32'h6835));
    srst = 1'b1;
    config_word = 14'h0;
    {config_erased, supply_rise, brownout_det, watchdog_expire} = 4'b1000;
    {cpu_sleeping, ext_clk_sel, por_flag_set, press_n} = 4'b0001;
    config_word = 14'($urandom);
    repeat (10) @(posedge clk_sys); // Held until conditions are good
    srst <= 1'b0;
    hit(0, 1, 1, {RSCS_CAUSE_POR, 5'b11010});
    @(negedge clk_sys);
    check({9'h0, osc_mode}, 11'h3);
    @(posedge clk_sys);
    config_erased <= 1'b0;
    config_word <= 14'h3ff4;
    for (int m = 0; m < 4; m++) begin
      x = 1'($urandom);
      @(posedge clk_sys);
      config_word[1:0] <= m[1:0];
      ext_clk_sel <= x;
      @(negedge clk_sys);
      check({9'h0, osc_mode}, {9'h0, m[1:0]});
      check({10'h0, osc_drive_en}, {10'h0, m != 3 && !(m == 2 && x)});
    end
    @(posedge clk_sys);
    config_word[1:0] <= 2'($urandom % 3);
    hit(0, 1, 1, {RSCS_CAUSE_POR, 5'b11011}); // Crystal start-up after power-on
    @(posedge clk_sys);
    por_flag_set <= 1'b1;
    @(posedge clk_sys);
    por_flag_set <= 1'b0;
    hit(2, 1 + $urandom % 3, 0, 11'h0); // Too short to count
    hit(2, 8, 1, {RSCS_CAUSE_CLR_RUN, 5'b11101});
    hit(3, 1, 1, {RSCS_CAUSE_DOG_RST, 5'b01101});
    check({10'h0, pin_drive_n}, 11'h1);
    cpu_sleeping <= 1'b1;
    hit(3, 1, 1, {RSCS_CAUSE_DOG_WAKE, 5'b00100});
    hit(2, 8, 1, {RSCS_CAUSE_CLR_SLP, 5'b10101});
    cpu_sleeping <= 1'b0;
    config_word[6] <= 1'b0;
    hit(1, 5, 0, 11'h0); // Brown-out disabled, no reset expected
    config_word[6] <= 1'b1;
    hit(1, 5, 1, {RSCS_CAUSE_BROWN, 5'b11101});
    check(11'(note_q.size()), 11'h0);
    print_verdict();
  end
endmodule : rscs_reset_seq_test
